// file: rtl/ccj_ctrl.v
// Collision signalling, heartbeat and jabber watchdog of a coax transceiver.
// Assumes the 10 MHz clock is the internal oscillator and that the squelch
// comparators and collision comparator deliver levels synchronous to it.
`timescale 1ns/10ps
`default_nettype none
`include "ccj_regs.vh"

// Notes on behaviour
// - Collision output is active whenever the comparator reports a collision level.
// - After transmission ends, heartbeat burst starts about 1.1 us later, lasts 1 us.
// - Heartbeat only when heartbeat select is high; otherwise never.
// - The 10 MHz clock drives collision output and times all jabber periods.
// - Collision pair toggles at oscillator rate during collision, jabber or heartbeat.
// - With no condition active the collision pair rests at zero differential.
// - Transmit active longer than 20 ms inhibits coax drive: jabber fault.
// - Collision indication stays asserted for the whole jabber fault.
// - After the fault clears, transmit stays inhibited for about 500 ms.
// - Squelch-qualified transmit data goes to coax drive unless jabber inhibits.
// - Transmit input idle for over 300 ns ends transmission, starting heartbeat delay.
module ccj_ctrl #(
   parameter JAB_LIMIT_CYC = `CCJ_JAB_LIMIT_CYC,
   parameter UNJAB_CYC     = `CCJ_UNJAB_CYC,
   parameter TIMER_W       = 23
) (
   input  wire sys_clk,
   input  wire reset,
   input  wire tx_data_in,
   input  wire tx_squelch_ok,
   output wire tx_ready,
   input  wire collision_cmp,
   input  wire heartbeat_select,
   output reg  coax_drive_output,
   output reg  coax_drive_en,
   output reg  collision_out_pos,
   output reg  collision_out_neg,
   output reg  collision_active,
   output reg  jabber_fault,
   output reg  tx_inhibit
);

   // ----------------------------------------------------------------
   // Constants and states
   // ----------------------------------------------------------------
   localparam HB_DELAY_N = `CCJ_HB_DELAY_CYC;
   localparam HB_WIDTH_N = `CCJ_HB_WIDTH_CYC;
   localparam TX_END_N   = `CCJ_TX_END_CYC;
   localparam [7:0] HB_DELAY = HB_DELAY_N[7:0];
   localparam [7:0] HB_WIDTH = HB_WIDTH_N[7:0];
   localparam [7:0] TX_END   = TX_END_N[7:0];
   localparam [TIMER_W-1:0] JAB_LIM = JAB_LIMIT_CYC[TIMER_W-1:0];
   localparam [TIMER_W-1:0] UNJAB   = UNJAB_CYC[TIMER_W-1:0];

   localparam [1:0] JS_IDLE  = 2'h0;
   localparam [1:0] JS_FAULT = 2'h1;
   localparam [1:0] JS_UNJAB = 2'h2;

   localparam [1:0] HS_IDLE  = 2'h0;
   localparam [1:0] HS_WAIT  = 2'h1;
   localparam [1:0] HS_BURST = 2'h2;

   reg [1:0]         jab_state_reg;
   reg [TIMER_W-1:0] jab_cnt_reg;
   reg               tx_active_reg;
   reg [7:0]         idle_cnt_reg;
   reg [1:0]         hb_state_reg;
   reg [7:0]         hb_cnt_reg;
   reg               osc_reg;
   reg               hb_on;
   reg               tx_end;

   wire       buf_valid;
   wire [1:0] buf_data;
   wire       qual_data;
   wire       qual_act;

   // ----------------------------------------------------------------
   // Transmit path buffer
   // ----------------------------------------------------------------
   // Output stage always drains; buffer only fills if that ever changes.
   ccj_skid_buf #(
      .WIDTH (2)
   ) u_buf (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .in_valid  (1'b1),
      .in_ready  (tx_ready),
      .in_data   ({tx_squelch_ok, tx_data_in}),
      .out_valid (buf_valid),
      .out_ready (1'b1),
      .out_data  (buf_data)
   );

   assign qual_act  = buf_valid & buf_data[1];
   assign qual_data = buf_data[0];

   // ----------------------------------------------------------------
   // Transmit activity and end detection
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         tx_active_reg <= 1'b0;
         idle_cnt_reg  <= 8'h00;
         tx_end        <= 1'b0;
      end else begin
         tx_end <= 1'b0;
         if (qual_act) begin
            tx_active_reg <= 1'b1;
            idle_cnt_reg  <= 8'h00;
         end else if (tx_active_reg) begin
            if (idle_cnt_reg >= TX_END) begin
               tx_active_reg <= 1'b0;
               tx_end        <= 1'b1;
            end else
               idle_cnt_reg <= idle_cnt_reg + 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------
   // Jabber watchdog
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         jab_state_reg <= JS_IDLE;
         jab_cnt_reg   <= {TIMER_W{1'b0}};
      end else begin
         case (jab_state_reg)
            JS_IDLE: begin
               if (!tx_active_reg)
                  jab_cnt_reg <= {TIMER_W{1'b0}};
               else if (jab_cnt_reg >= JAB_LIM) begin
                  jab_state_reg <= JS_FAULT;
                  jab_cnt_reg   <= {TIMER_W{1'b0}};
               end else
                  jab_cnt_reg <= jab_cnt_reg + 1'b1;
            end
            JS_FAULT: begin
               if (!tx_active_reg)
                  jab_state_reg <= JS_UNJAB;
            end
            JS_UNJAB: begin
               if (tx_active_reg) begin
                  jab_state_reg <= JS_FAULT;
                  jab_cnt_reg   <= {TIMER_W{1'b0}};
               end else if (jab_cnt_reg >= UNJAB - 1'b1) begin
                  jab_state_reg <= JS_IDLE;
                  jab_cnt_reg   <= {TIMER_W{1'b0}};
               end else
                  jab_cnt_reg <= jab_cnt_reg + 1'b1;
            end
            default: begin
               jab_state_reg <= JS_IDLE;
               jab_cnt_reg   <= {TIMER_W{1'b0}};
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Heartbeat generator
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         hb_state_reg <= HS_IDLE;
         hb_cnt_reg   <= 8'h00;
      end else begin
         case (hb_state_reg)
            HS_IDLE: begin
               if (tx_end && heartbeat_select) begin
                  hb_state_reg <= HS_WAIT;
                  hb_cnt_reg   <= 8'h00;
               end
            end
            HS_WAIT: begin
               if (hb_cnt_reg >= HB_DELAY - 8'h01) begin
                  hb_state_reg <= HS_BURST;
                  hb_cnt_reg   <= 8'h00;
               end else
                  hb_cnt_reg <= hb_cnt_reg + 8'h01;
            end
            HS_BURST: begin
               if (hb_cnt_reg >= HB_WIDTH - 8'h01) begin
                  hb_state_reg <= HS_IDLE;
                  hb_cnt_reg   <= 8'h00;
               end else
                  hb_cnt_reg <= hb_cnt_reg + 8'h01;
            end
            default: begin
               hb_state_reg <= HS_IDLE;
               hb_cnt_reg   <= 8'h00;
            end
         endcase
      end
   end

   always @* begin
      hb_on = (hb_state_reg == HS_BURST) && heartbeat_select;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         osc_reg           <= 1'b0;
         collision_out_pos <= 1'b0;
         collision_out_neg <= 1'b0;
         collision_active  <= 1'b0;
         jabber_fault      <= 1'b0;
         tx_inhibit        <= 1'b0;
         coax_drive_output <= 1'b0;
         coax_drive_en     <= 1'b0;
      end else begin
         osc_reg      <= ~osc_reg;
         jabber_fault <= (jab_state_reg == JS_FAULT);
         tx_inhibit   <= (jab_state_reg != JS_IDLE);
         collision_active <= collision_cmp || hb_on
                             || (jab_state_reg == JS_FAULT);
         if (collision_cmp || hb_on || (jab_state_reg == JS_FAULT)) begin
            collision_out_pos <= ~osc_reg;
            collision_out_neg <= osc_reg;
         end else begin
            collision_out_pos <= 1'b0;
            collision_out_neg <= 1'b0;
         end
         if (qual_act && (jab_state_reg == JS_IDLE) && !(tx_active_reg
             && jab_cnt_reg >= JAB_LIM)) begin
            coax_drive_output <= qual_data;
            coax_drive_en     <= 1'b1;
         end else begin
            coax_drive_output <= 1'b0;
            coax_drive_en     <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// file: rtl/ccj_regs.vh
// Constants of the coax collision and jabber control block.
// Assumes a 10 MHz system clock; counts derive from the times below.
`ifndef CCJ_REGS_VH
`define CCJ_REGS_VH

`define CCJ_CLK_HZ            10000000
// Times as printed, in their own units
`define CCJ_HB_DELAY_NS       1100
`define CCJ_HB_WIDTH_NS       1000
`define CCJ_TX_END_NS         300
`define CCJ_JAB_LIMIT_MS      20
`define CCJ_UNJAB_MS          500
// Cycle counts derived from the times above
`define CCJ_HB_DELAY_CYC      ((`CCJ_HB_DELAY_NS * (`CCJ_CLK_HZ / 1000000)) / 1000)
`define CCJ_HB_WIDTH_CYC      ((`CCJ_HB_WIDTH_NS * (`CCJ_CLK_HZ / 1000000)) / 1000)
`define CCJ_TX_END_CYC       ((`CCJ_TX_END_NS * (`CCJ_CLK_HZ / 1000000)) / 1000)
`define CCJ_JAB_LIMIT_CYC     (`CCJ_JAB_LIMIT_MS * (`CCJ_CLK_HZ / 1000))
`define CCJ_UNJAB_CYC         (`CCJ_UNJAB_MS * (`CCJ_CLK_HZ / 1000))
// Buffer depth
`define CCJ_BUF_DEPTH         2

`endif

// file: rtl/ccj_skid_buf.v
// Two-entry buffer with valid/ready on both sides.
// Assumes one clock; the drain side may stall at any time.
`timescale 1ns/10ps
`default_nettype none

module ccj_skid_buf #(
   parameter WIDTH = 1
) (
   input  wire             sys_clk,
   input  wire             reset,
   input  wire             in_valid,
   output wire             in_ready,
   input  wire [WIDTH-1:0] in_data,
   output wire             out_valid,
   input  wire             out_ready,
   output wire [WIDTH-1:0] out_data
);

   reg [WIDTH-1:0] mem_reg [0:1];
   reg             wr_ptr_reg;
   reg             rd_ptr_reg;
   reg [1:0]       count_reg;
   wire            push;
   wire            pop;

   assign in_ready  = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data  = mem_reg[rd_ptr_reg];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         mem_reg[0] <= {WIDTH{1'b0}};
         mem_reg[1] <= {WIDTH{1'b0}};
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
            wr_ptr_reg          <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         if (push & ~pop)
            count_reg <= count_reg + 2'h1;
         else if (pop & ~push)
            count_reg <= count_reg - 2'h1;
      end
   end

endmodule

`default_nettype wire

// file: verif/ccj_ctrl_monitor.sv
// Port checker for ccj_ctrl.
// Assumes one clock, sys_clk, and the async active-high reset.
`timescale 1ns/10ps
`default_nettype none
module ccj_ctrl_mon #(
   parameter JAB_LIMIT_CYC = 50,
   parameter UNJAB_CYC     = 100
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic tx_data_in,
   input wire logic collision_cmp,
   input wire logic coax_drive_output,
   input wire logic coax_drive_en,
   input wire logic collision_out_pos,
   input wire logic collision_out_neg,
   input wire logic collision_active,
   input wire logic jabber_fault,
   input wire logic tx_inhibit
);
   int unjab_cnt;
   int drive_cnt;
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         unjab_cnt <= 0;
         drive_cnt <= 0;
      end else begin
         unjab_cnt <= (tx_inhibit && !jabber_fault) ? unjab_cnt + 1 : 0;
         drive_cnt <= coax_drive_en ? drive_cnt + 1 : 0;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   property p_col_on; $rose(collision_cmp) |-> ##[1:3] collision_active; endproperty
   a_col_on: assert property (p_col_on) else $error("collision not shown");
   property p_tog; collision_active[*4] |-> (collision_out_pos ^ collision_out_neg)
      && collision_out_pos != $past(collision_out_pos); endproperty
   a_tog: assert property (p_tog) else $error("pair not toggling");
   property p_idle; !collision_active[*3] |-> !collision_out_pos && !collision_out_neg;
   endproperty
   a_idle: assert property (p_idle) else $error("pair not idle");
   property p_jab_off; tx_inhibit[*2] |-> !coax_drive_en; endproperty
   a_jab_off: assert property (p_jab_off) else $error("drive while inhibited");
   property p_jab_lim; coax_drive_en |-> drive_cnt <= JAB_LIMIT_CYC + 3; endproperty
   a_jab_lim: assert property (p_jab_lim) else $error("drive past limit");
   property p_jab_col; jabber_fault[*3] |-> collision_active; endproperty
   a_jab_col: assert property (p_jab_col) else $error("fault without collision");
   property p_unjab; $fell(tx_inhibit) |-> unjab_cnt >= UNJAB_CYC - 3
      && unjab_cnt <= UNJAB_CYC + 3; endproperty
   a_unjab: assert property (p_unjab) else $error("unjab length wrong");
   property p_drive; coax_drive_en |-> coax_drive_output == $past(tx_data_in, 2); endproperty
   a_drive: assert property (p_drive) else $error("drive data wrong");
   cover property (jabber_fault);
   cover property ($fell(tx_inhibit));
   cover property (collision_active && !collision_cmp);
endmodule
`default_nettype wire

// file: verif/ccj_term_model.sv
// Data terminal model driving the transmit input.
// Assumes go is a one-cycle pulse while the model is idle.
`timescale 1ns/10ps
`default_nettype none
module ccj_term_model (
   input  wire logic        sys_clk,
   input  wire logic        go,
   input  wire logic [15:0] len,
   input  wire logic [31:0] pat,
   input  wire logic        unjab,
   output var  logic        tx_data_in,
   output var  logic        tx_squelch_ok,
   output wire logic        busy
);
   logic [15:0] n = 16'h0;
   assign busy = n != 16'h0;
   initial tx_data_in = 1'b0;
   initial tx_squelch_ok = 1'b0;
   always @(posedge sys_clk) begin
      if (busy) begin
         tx_data_in <= pat[n[4:0]];
         tx_squelch_ok <= n != 16'h1;
         n <= n - 16'h1;
      end else if (go && !unjab) begin
         tx_data_in <= pat[31];
         tx_squelch_ok <= 1'b1;
         n <= len;
      end else begin
         // Released line shows no stale level
         tx_data_in <= ~tx_data_in;
         tx_squelch_ok <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: verif/ccj_ctrl_tb.sv
// Self-checking bench for ccj_ctrl.
// Assumes the terminal model and the port checker bound below.
`timescale 1ns/10ps
`default_nettype none
module ccj_ctrl_tb;
   localparam int JAB = 50;
   localparam int UNJ = 100;
   logic        sys_clk = 1'b0;
   logic        reset   = 1'b1;
   logic        go      = 1'b0;
   logic        hb_sel  = 1'b1;
   logic        col_cmp = 1'b0;
   logic        q_on    = 1'b1;
   logic        sq_d    = 1'b0;
   logic        act_d   = 1'b0;
   logic [15:0] len     = 16'h0;
   logic [31:0] pat     = 32'h0;
   logic [31:0] rng     = 32'hb767;
   logic        exp_q[$];
   wire         tx_d, tx_sq, busy, drv, drv_en, cd_p, cd_n, col_act, jab, inh, tx_rdy;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0, act_cnt = 0, drv_cnt = 0, end_cyc = 0, rise_cyc = 0, jab_seen = 0;
   int a0, d0, l;
   always #50 sys_clk = ~sys_clk;
   ccj_ctrl #(.JAB_LIMIT_CYC(JAB), .UNJAB_CYC(UNJ)) u_dut (
      .sys_clk(sys_clk), .reset(reset), .tx_data_in(tx_d), .tx_squelch_ok(tx_sq),
      .tx_ready(tx_rdy), .collision_cmp(col_cmp), .heartbeat_select(hb_sel),
      .coax_drive_output(drv), .coax_drive_en(drv_en), .collision_out_pos(cd_p),
      .collision_out_neg(cd_n), .collision_active(col_act), .jabber_fault(jab),
      .tx_inhibit(inh));
   ccj_term_model u_term (.sys_clk(sys_clk), .go(go), .len(len), .pat(pat),
      .unjab(inh), .tx_data_in(tx_d), .tx_squelch_ok(tx_sq), .busy(busy));
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      cmp_count++;
      if (seen !== expd) begin
         err_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expd);
      end
   endtask
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic run(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic frame(input int n);
      rng = xs(rng);
      @(posedge sys_clk);
      pat <= rng;
      len <= 16'(n);
      go <= 1'b1;
      @(posedge sys_clk);
      go <= 1'b0;
      run(n + 3);
   endtask
   // Reference: while q_on is set, every qualified bit comes back on the coax drive in order
   always @(posedge sys_clk) begin
      if (!reset) begin
         cyc++;
         if (tx_sq) exp_q.push_back(tx_d);
         if (drv_en && q_on) check(drv, exp_q.size() ? exp_q.pop_front() : ~drv);
         if (sq_d && !tx_sq) end_cyc = cyc;
         if (col_act && !act_d) rise_cyc = cyc;
         act_cnt += col_act;
         drv_cnt += drv_en;
         jab_seen |= jab;
         if (col_act) check(cd_p ^ cd_n, 1);
         else check(cd_p | cd_n, 0);
         sq_d = tx_sq;
         act_d = col_act;
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      for (int h = 1; h >= 0; h--) begin
         @(posedge sys_clk);
         hb_sel <= h[0];
         a0 = act_cnt;
         frame(20 + rng[3:0]);
         run(40);
         check(act_cnt - a0, h ? 10 : 0);
         if (h) check(rise_cyc - end_cyc >= 14 && rise_cyc - end_cyc <= 19, 1);
      end
      $display("heartbeat test done");
      rng = xs(rng);
      l = 5 + rng[3:0];
      a0 = act_cnt;
      @(posedge sys_clk);
      col_cmp <= 1'b1;
      repeat (l) @(posedge sys_clk);
      col_cmp <= 1'b0;
      run(10);
      check(act_cnt - a0 >= l && act_cnt - a0 <= l + 2, 1);
      $display("collision test done");
      q_on = 1'b0;
      d0 = drv_cnt;
      frame(JAB + 30);
      check(jab_seen, 1);
      check(drv_cnt - d0 >= JAB - 3 && drv_cnt - d0 <= JAB + 3, 1);
      run(20);
      check(inh, 1);
      run(UNJ + 20);
      check(inh, 0);
      exp_q.delete();
      q_on = 1'b1;
      d0 = drv_cnt;
      frame(12);
      check(drv_cnt - d0, 12);
      check(exp_q.size(), 0);
      check(tx_rdy, 1);
      $display("jabber test done");
      print_verdict();
   end
   initial begin
      #200000;
      err_count++;
      print_verdict();
   end
endmodule
bind ccj_ctrl ccj_ctrl_mon #(.JAB_LIMIT_CYC(JAB_LIMIT_CYC), .UNJAB_CYC(UNJAB_CYC)) u_mon (
   .sys_clk, .reset, .tx_data_in, .collision_cmp, .coax_drive_output, .coax_drive_en,
   .collision_out_pos, .collision_out_neg, .collision_active, .jabber_fault, .tx_inhibit);
`default_nettype wire
